// ===== verilog/battery_monitor_and_power_defaults.sv
// Battery check, reset input filtering and control bit defaults
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module battery_monitor_and_power_defaults
  import batt_mon_pkg::*;
#(
  parameter int RST2_CYC = RST2_MIN_CYC,
  parameter int RSTOUT_LEN = RSTOUT_CYC,
  parameter longint CHECK_LEN = CHECK_CYC
)
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [7:0] writedata,
  output logic [7:0] readdata,
  output logic waitrequest,
  input wire logic reset_input_one_b,
  input wire logic reset_input_two_b,
  input wire logic supplyGood,
  input wire logic batteryLow,
  input wire logic batteryFirstAttach,
  output logic resetOut_b,
  output logic [7:0] watchdogOut,
  output logic [7:0] controlOut,
  output logic alarmFlagEnableOut,
  output logic alarmBackupEnableOut,
  output logic frequencyTestOut
);
  //==========================================================
  // Synchronisers
  logic supA_reg, supB_reg, batA_reg, batB_reg, attA_reg, attB_reg;
  logic supPrev_reg;
  logic powerUp, powerDown;
  assign powerUp = supB_reg && !supPrev_reg;
  assign powerDown = !supB_reg && supPrev_reg;
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      supA_reg <= 1'b0;
      supB_reg <= 1'b0;
      batA_reg <= 1'b0;
      batB_reg <= 1'b0;
      attA_reg <= 1'b0;
      attB_reg <= 1'b0;
      supPrev_reg <= 1'b0;
    end
    else
    begin
      supA_reg <= supplyGood;
      supB_reg <= supA_reg;
      batA_reg <= batteryLow;
      batB_reg <= batA_reg;
      attA_reg <= batteryFirstAttach;
      attB_reg <= attA_reg;
      supPrev_reg <= supB_reg;
    end
  end
  //==========================================================
  // Reset inputs and reset output
  logic acceptOne, acceptTwo;
  logic [31:0] rstCount_reg;
  logic [31:0] rstCount_next;
  logic startReset;
  logic resetActive;
  assign resetActive = rstCount_reg != 32'h0;
  pulse_filter #(.MIN_CYC(RST1_MIN_CYC)) filterOne
  (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pinIn(reset_input_one_b),
    .ignore(resetActive),
    .accepted(acceptOne)
  );
  pulse_filter #(.MIN_CYC(RST2_CYC)) filterTwo
  (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pinIn(reset_input_two_b),
    .ignore(resetActive),
    .accepted(acceptTwo)
  );
  // Filters already drop pulses while active; power-up always restarts the hold
  assign startReset = acceptOne || acceptTwo || powerUp;
  assign rstCount_next = startReset ? 32'(RSTOUT_LEN) :
                         (!supB_reg ? 32'h1 : (resetActive ? rstCount_reg - 32'h1 : 32'h0));
  //==========================================================
  // Battery check scheduling
  logic [47:0] checkCount_reg;
  logic doCheck;
  logic battFlag_reg;
  assign doCheck = supB_reg && (powerUp || checkCount_reg == 48'(CHECK_LEN - 1));
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      checkCount_reg <= 48'h0;
      battFlag_reg <= 1'b0;
      rstCount_reg <= 32'h1;
    end
    else
    begin
      rstCount_reg <= rstCount_next;
      checkCount_reg <= (!supB_reg || doCheck) ? 48'h0 : checkCount_reg + 48'h1;
      if (doCheck)
        battFlag_reg <= batB_reg;
    end
  end
  //==========================================================
  // Address decode
  function automatic logic addrHit(input logic [3:0] addr, input logic [3:0] target);
    return addr == target;
  endfunction : addrHit
  logic hitFlags, hitWatchdog, hitControl, hitAlarmMonth, hitFreq;
  assign hitFlags = addrHit(address, ADDR_FLAGS);
  assign hitWatchdog = addrHit(address, ADDR_WATCHDOG);
  assign hitControl = addrHit(address, ADDR_CONTROL);
  assign hitAlarmMonth = addrHit(address, ADDR_ALARM_MONTH);
  assign hitFreq = addrHit(address, ADDR_FREQ);
  //==========================================================
  // Control bits
  logic [7:0] wdog_reg, ctrl_reg, almMon_reg, freq_reg;
  logic busWrite, firstUp, laterUp, clearOnUp;
  logic wrWatchdog, wrControl, wrAlarmMonth, wrFreq;
  // Writes land only at the edge that completes the transfer
  assign busWrite = write && !waitrequest && supB_reg;
  assign firstUp = powerUp && attB_reg;
  assign laterUp = (powerUp && !attB_reg) || acceptOne || acceptTwo;
  assign clearOnUp = firstUp || laterUp;
  assign wrWatchdog = busWrite && hitWatchdog;
  assign wrControl = busWrite && hitControl;
  assign wrAlarmMonth = busWrite && hitAlarmMonth;
  assign wrFreq = busWrite && hitFreq;
  // Power and reset events win over a write in the same cycle
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      wdog_reg <= RESET_BYTE;
    else if (clearOnUp || powerDown)
      wdog_reg <= RESET_BYTE;
    else if (wrWatchdog)
      wdog_reg <= writedata;
  end
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      ctrl_reg <= RESET_BYTE;
    else if (clearOnUp || powerDown)
    begin
      ctrl_reg[BIT_WRITE] <= 1'b0;
      ctrl_reg[BIT_READ] <= 1'b0;
    end
    else if (wrControl)
      ctrl_reg <= writedata;
  end
  // Alarm enables survive power-down
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      almMon_reg <= RESET_BYTE;
    else if (clearOnUp)
    begin
      almMon_reg[BIT_ALARM_FLAG_EN] <= 1'b0;
      almMon_reg[BIT_ALARM_BACKUP_EN] <= 1'b0;
    end
    else if (wrAlarmMonth)
      almMon_reg <= writedata;
  end
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      freq_reg <= RESET_BYTE;
    else if (clearOnUp || powerDown)
      freq_reg[BIT_FREQ_TEST] <= 1'b0;
    else if (wrFreq)
      freq_reg <= writedata;
  end
  //==========================================================
  // Bus read path
  logic [7:0] flagsByte;
  logic [7:0] readMux;
  assign flagsByte = 8'(battFlag_reg) << BIT_BATT_LOW;
  assign readMux = hitFlags ? flagsByte :
                   hitWatchdog ? wdog_reg :
                   hitControl ? ctrl_reg :
                   hitAlarmMonth ? almMon_reg :
                   hitFreq ? freq_reg : 8'h00;
  //==========================================================
  // Bus response
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      readdata <= 8'h00;
      waitrequest <= 1'b1;
    end
    else
    begin
      // Answer one cycle after request, then release
      waitrequest <= !((read || write) && waitrequest);
      readdata <= readMux;
    end
  end
  //==========================================================
  // Registered outputs
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      resetOut_b <= 1'b0;
      watchdogOut <= 8'h00;
      controlOut <= 8'h00;
      alarmFlagEnableOut <= 1'b0;
      alarmBackupEnableOut <= 1'b0;
      frequencyTestOut <= 1'b0;
    end
    else
    begin
      resetOut_b <= !resetActive;
      watchdogOut <= wdog_reg;
      controlOut <= ctrl_reg;
      alarmFlagEnableOut <= almMon_reg[BIT_ALARM_FLAG_EN];
      alarmBackupEnableOut <= almMon_reg[BIT_ALARM_BACKUP_EN];
      frequencyTestOut <= freq_reg[BIT_FREQ_TEST];
    end
  end
endmodule : battery_monitor_and_power_defaults
`default_nettype wire

// ===== verilog/batt_mon_pkg.sv
// Constants for the battery monitor and power defaults block
//=============================================================
package batt_mon_pkg;
  localparam int CLK_MHZ = 100;
  localparam int CLK_PERIOD_NS = 10;
  localparam int RST1_MIN_NS = 50;
  localparam int RST1_MIN_CYC = (RST1_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST2_MIN_MS = 20;
  localparam int RST2_MIN_CYC = RST2_MIN_MS * 1000 * CLK_MHZ;
  localparam int RSTOUT_MS = 100;
  localparam int RSTOUT_CYC = RSTOUT_MS * 1000 * CLK_MHZ;
  localparam int CHECK_HOURS = 24;
  localparam longint CHECK_CYC = longint'(CHECK_HOURS) * 3600 * 1000000 * CLK_MHZ;
  localparam logic [3:0] ADDR_FLAGS = 4'h0;
  localparam logic [3:0] ADDR_WATCHDOG = 4'h7;
  localparam logic [3:0] ADDR_CONTROL = 4'h8;
  localparam logic [3:0] ADDR_ALARM_MONTH = 4'h6;
  localparam logic [3:0] ADDR_FREQ = 4'hc;
  localparam int BIT_BATT_LOW = 4;
  localparam int BIT_WRITE = 7;
  localparam int BIT_READ = 6;
  localparam int BIT_ALARM_FLAG_EN = 7;
  localparam int BIT_ALARM_BACKUP_EN = 5;
  localparam int BIT_FREQ_TEST = 6;
  localparam logic [7:0] RESET_BYTE = 8'h00;
endpackage : batt_mon_pkg

// ===== verilog/pulse_filter.sv
// Low pulse filter for one reset input
`timescale 1ns/1ps
`default_nettype none
module pulse_filter
#(
  parameter int MIN_CYC = 5
)
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic pinIn,
  input wire logic ignore,
  output logic accepted
);
  localparam int CW = $clog2(MIN_CYC + 2);
  logic syncA_reg;
  logic syncB_reg;
  logic [CW-1:0] count_reg;
  logic [CW-1:0] countNext;
  logic longEnough;
  assign longEnough = count_reg >= CW'(MIN_CYC);
  assign countNext = (syncB_reg || ignore) ? '0 : (longEnough ? count_reg : count_reg + CW'(1));
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      syncA_reg <= 1'b1;
      syncB_reg <= 1'b1;
      count_reg <= '0;
      accepted <= 1'b0;
    end
    else
    begin
      syncA_reg <= pinIn;
      syncB_reg <= syncA_reg;
      count_reg <= countNext;
      // Pulse once the low pulse ends after passing the minimum
      accepted <= syncB_reg && longEnough && !ignore;
    end
  end
endmodule : pulse_filter
`default_nettype wire

// ===== testbench/batt_mon_assertions.sv
// Port checker for the battery monitor block
`timescale 1ns/1ps
`default_nettype none
module batt_mon_assertions
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic reset_input_one_b,
  input wire logic supplyGood,
  input wire logic resetOut_b,
  input wire logic [7:0] watchdogOut,
  input wire logic [7:0] controlOut,
  input wire logic alarmFlagEnableOut,
  input wire logic alarmBackupEnableOut,
  input wire logic frequencyTestOut
);
  //==========
  // Checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic volClear;
  assign volClear = watchdogOut == 8'h00 && !frequencyTestOut && controlOut[7:6] == 2'b00;
  a_wait_pulse: assert property (!waitrequest |=> waitrequest) else $error("long answer");
  a_req_answer: assert property ((read || write) && waitrequest |=> !waitrequest) else $error("no answer");
  a_pwrup_hold: assert property ($rose(supplyGood) |=> !resetOut_b [*8]) else $error("short reset");
  a_supply_low: assert property (!supplyGood [*5] |-> !resetOut_b) else $error("reset off");
  a_pulse_short: assert property (resetOut_b && $rose(reset_input_one_b) && $past(reset_input_one_b, 2)
    |=> resetOut_b [*6]) else $error("glitch reset");
  a_pwrup_clear: assert property ($rose(supplyGood) |-> ##[1:8] (volClear && !alarmFlagEnableOut
    && !alarmBackupEnableOut)) else $error("power-up bits");
  a_pwrdn_clear: assert property ($fell(supplyGood) |-> ##[1:8] volClear) else $error("power-down bits");
  a_pwrdn_keep: assert property ($fell(supplyGood) && alarmFlagEnableOut |=> alarmFlagEnableOut [*3])
    else $error("alarm enable lost");
  c_write: cover property (write && !waitrequest);
  c_read: cover property (read && !waitrequest);
  c_reset: cover property ($fell(resetOut_b) && supplyGood);
endmodule : batt_mon_assertions
`default_nettype wire

// ===== testbench/avalon_host.sv
// Host model driving the register bus
`timescale 1ns/1ps
`default_nettype none
module avalon_host
(
  input wire logic core_clk,
  input wire logic waitrequest,
  input wire logic [7:0] readdata,
  output logic [3:0] address = 4'h0,
  output logic read = 1'b0,
  output logic write = 1'b0,
  output logic [7:0] writedata = 8'h00
);
  //==========
  // Transfer
  task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge core_clk);
    address <= a;
    writedata <= d;
    read <= !w;
    write <= w;
    do @(posedge core_clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : xfer
endmodule : avalon_host
`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking bench for the battery monitor block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
  import batt_mon_pkg::*;
  logic core_clk = 1'b0, rst_b = 1'b0, supplyGood = 1'b0, batteryLow = 1'b1, batteryFirstAttach = 1'b1;
  logic reset_input_one_b = 1'b1, reset_input_two_b = 1'b1;
  logic read, write, waitrequest, resetOut_b, alarmFlagOut, alarmBackupOut, freqTestOut;
  logic [3:0] address;
  logic [7:0] writedata, readdata, watchdogOut, controlOut, q;
  int n_fail = 0, n_checks = 0, cyc = 0;
  battery_monitor_and_power_defaults #(.RST2_CYC(10), .RSTOUT_LEN(20), .CHECK_LEN(50)) uut (.core_clk, .rst_b,
    .address, .read, .write, .writedata, .readdata, .waitrequest, .reset_input_one_b, .reset_input_two_b,
    .supplyGood, .batteryLow, .batteryFirstAttach, .resetOut_b, .watchdogOut, .controlOut,
    .alarmFlagEnableOut(alarmFlagOut), .alarmBackupEnableOut(alarmBackupOut), .frequencyTestOut(freqTestOut));
  avalon_host host (.core_clk, .waitrequest, .readdata, .address, .read, .write, .writedata);
  //==========
  // Tasks
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      results();
    end
  end
  task results;
    $display("checks=%0d fails=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results
  task rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    host.xfer(1'b0, a, 8'h00, q);
    `CHK(q & m, e)
  endtask : rd
  task loadRegs;
    host.xfer(1'b1, ADDR_WATCHDOG, 8'ha5, q);
    host.xfer(1'b1, ADDR_CONTROL, 8'hc3, q);
    host.xfer(1'b1, ADDR_ALARM_MONTH, 8'ha0, q);
    host.xfer(1'b1, ADDR_FREQ, 8'h40, q);
  endtask : loadRegs
  task outs(input logic [7:0] wd, input logic [7:0] ctl, input logic [2:0] bits);
    repeat (2) @(posedge core_clk);
    `CHK({watchdogOut, controlOut, alarmFlagOut, alarmBackupOut, freqTestOut}, {wd, ctl, bits})
  endtask : outs
  task pulse(input logic two, input int n);
    @(posedge core_clk);
    if (two) reset_input_two_b <= 1'b0;
    else reset_input_one_b <= 1'b0;
    repeat (n) @(posedge core_clk);
    reset_input_one_b <= 1'b1;
    reset_input_two_b <= 1'b1;
    repeat (8) @(posedge core_clk);
  endtask : pulse
  task settle;
    repeat (8) @(posedge core_clk);
    `CHK(resetOut_b, 1'b0)
    while (resetOut_b !== 1'b1) @(posedge core_clk);
  endtask : settle
  //==========
  // Sequence
  initial
  begin
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    supplyGood <= 1'b1;
    settle();
    rd(ADDR_FLAGS, 8'h10, 8'h10);
    batteryFirstAttach <= 1'b0;
    host.xfer(1'b1, ADDR_FLAGS, 8'hff, q);
    batteryLow <= 1'b0;
    rd(ADDR_FLAGS, 8'h10, 8'h10);
    repeat (60) @(posedge core_clk);
    rd(ADDR_FLAGS, 8'h10, 8'h00);
    rd(4'h1, 8'hff, 8'h00);
    loadRegs();
    outs(8'ha5, 8'hc3, 3'b111);
    for (int n = 1; n < 4; n++) pulse(1'b0, n);
    pulse(1'b1, 5);
    `CHK(resetOut_b, 1'b1)
    pulse(1'b0, 8);
    settle();
    outs(8'h00, 8'h03, 3'b000);
    loadRegs();
    pulse(1'b1, 15);
    settle();
    outs(8'h00, 8'h03, 3'b000);
    loadRegs();
    batteryLow <= 1'b1;
    supplyGood <= 1'b0;
    repeat (10) @(posedge core_clk);
    outs(8'h00, 8'h03, 3'b110);
    repeat (60) @(posedge core_clk);
    rd(ADDR_FLAGS, 8'h10, 8'h00);
    batteryLow <= 1'b0;
    supplyGood <= 1'b1;
    settle();
    outs(8'h00, 8'h03, 3'b000);
    loadRegs();
    supplyGood <= 1'b0;
    repeat (10) @(posedge core_clk);
    batteryFirstAttach <= 1'b1;
    supplyGood <= 1'b1;
    settle();
    outs(8'h00, 8'h03, 3'b000);
    results();
  end
endmodule : tb_top
bind battery_monitor_and_power_defaults batt_mon_assertions chk (.core_clk, .rst_b, .read, .write,
  .waitrequest, .reset_input_one_b, .supplyGood, .resetOut_b, .watchdogOut, .controlOut,
  .alarmFlagEnableOut, .alarmBackupEnableOut, .frequencyTestOut);
`default_nettype wire
